// file: verilog/reset_seq_pkg.sv
// Constants, register map and state encoding of the reset sequencer.
// Assumes one system clock; all oscillator counts are in oscillator cycles.
package reset_seq_pkg;
	// Oscillator-cycle counts and counter widths
	localparam int OSC_LONG_CYCLES = 4096;
	localparam int PIN_DRIVE_CYCLES = 32;
	localparam int RESET_HOLD_CYCLES = 32;
	localparam int SHORT_STOP_CYCLES = 32;
	localparam int PIN_THR_OTHER = 67;
	localparam int PIN_THR_PORLVI = 4163;
	localparam int SEQ_W = 13;
	localparam int PRESCALE_W = 12;
	// Register byte addresses
	localparam logic [11:0] CAUSE_ADDR = 12'h000;
	localparam logic [11:0] OPTION_ADDR = 12'h004;
	localparam logic [11:0] STATE_ADDR = 12'h008;
	// Cause register fields
	localparam int CAUSE_POR_BIT = 7;
	localparam int CAUSE_PIN_BIT = 6;
	localparam int CAUSE_WDT_BIT = 5;
	localparam int CAUSE_ILLEGAL_OPCODE_FLAG_BIT = 4;
	localparam int CAUSE_ILLEGAL_ADDRESS_FLAG_BIT = 3;
	localparam int CAUSE_LVI_BIT = 1;
	localparam logic [7:0] CAUSE_RESET = 8'h80;
	localparam logic [7:0] CAUSE_MASK = 8'hFA;
	// Option register fields
	localparam int OPT_WDT_DIS_BIT = 0;
	localparam int OPT_STOP_EN_BIT = 1;
	localparam int OPT_SHORT_STOP_BIT = 2;
	localparam int OPT_LV_PWR_BIT = 3;
	localparam int OPT_LV_RST_BIT = 4;
	localparam logic [4:0] OPTION_RESET = 5'h00;
	// Opcodes and vectors
	localparam logic [7:0] OP_SP_PREFIX = 8'h9E;
	localparam logic [7:0] OP_STOP = 8'h8E;
	localparam logic [15:0] VEC_USER = 16'hFFFE;
	localparam logic [15:0] VEC_MONITOR = 16'hFEFE;

	typedef enum logic [2:0] {
		S_RUN = 3'b000,
		S_LONG = 3'b001,
		S_DRIVE = 3'b010,
		S_HOLD = 3'b011,
		S_EXT = 3'b100,
		S_STOP = 3'b101,
		S_RECOVER = 3'b110
	} state_t;
endpackage : reset_seq_pkg

// file: verilog/reset_sequencer.sv
// Reset sequencer: reset sources, reset pin drive, cause flags, prescale counter.
// Assumes APB master on pclk; oscillator clock and CPU signals synchronous inputs.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps

// Operation
// - Every reset asserts internal reset, selects vector
// - Internal reset returns registers to defaults
// - Internal resets clear counter, pin reset not
// - Each source sets its own cause flag
// - Pin low halts; pin flag needs 67 cycles
// - Pin flag threshold 4163 after POR/LOW_VOLTAGE_FLAG
// - Internal sources drive pin low 32 cycles
// - Internal reset held 32 more after release
// - POR/LOW_VOLTAGE_FLAG count 4096 with pin low first
// - Watchdog request accepted asynchronously
// - Power-on: 4096 pin low, 64 more
// - Power-on: main clock on, bus clocks off
// - Power-on sets POR flag, clears others
// - Watchdog overflow resets unless disabled
// - Illegal opcode sets flag and resets
// - Prefix 9E then 8E gives reset
// - Stop disabled makes stop illegal opcode
// - Unmapped opcode fetch only gives address reset
// - Low voltage resets when both config bits set
// - After low voltage: 4096 then 64 cycles
// - 12-bit counter on oscillator falling edge
// - Stop clears counter; recovery 32 or 4096
// - Timing uses buffered oscillator clock only
module reset_sequencer import reset_seq_pkg::*; #(
	parameter int LONG_CYCLES = OSC_LONG_CYCLES,
	parameter int PIN_THR_LONG = PIN_THR_PORLVI
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock and reset sources
	input wire logic osc_buffered_clk,
	input wire logic power_on_pulse,
	input wire logic watchdog_overflow,
	input wire logic low_voltage_detect,
	// CPU observation
	input wire logic opcode_fetch,
	input wire logic [7:0] fetch_opcode,
	input wire logic fetch_unmapped,
	input wire logic illegal_opcode_detect,
	input wire logic wake_event,
	input wire logic monitor_mode,
	// Reset pin
	input wire logic rst_pin_in,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	// System outputs
	output logic internal_reset,
	output logic [15:0] reset_vector,
	output logic main_clock_out,
	output logic internal_bus_clocks,
	output logic watchdog_clk
);
	state_t state_r, state_nxt;
	logic osc_d_r, tick;
	logic pin_s1_r, pin_s2_r, pin_low;
	logic wdt_s1_r, wdt_s2_r, wdt_s3_r, wdt_req;
	logic [SEQ_W-1:0] seq_r, seq_nxt;
	logic [SEQ_W-1:0] pin_cnt_r;
	logic [PRESCALE_W-1:0] prescale_r;
	logic [7:0] cause_r;
	logic [4:0] option_r;
	logic por_lvi_r, prev_prefix_r;
	logic stop_op, seq_illegal_opcode_flag, seq_illegal_address_flag, seq_wdt, seq_lvi, int_src;
	logic enter_stop, clr_prescale;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r, wr_en;
	logic rst_oe_r, internal_reset_r, mclk_r, bus_clk_r, wdt_clk_r;
	logic [15:0] vector_r;

	function automatic logic count_done(input logic [SEQ_W-1:0] cnt, input int limit);
		count_done = (cnt == SEQ_W'(limit - 1));
	endfunction : count_done

	// Oscillator falling edge, sampled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_d_r <= 1'b0;
		end else begin
			osc_d_r <= osc_buffered_clk;
		end
	end
	assign tick = osc_d_r & ~osc_buffered_clk;

	// Pin synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
		end else begin
			pin_s1_r <= rst_pin_in;
			pin_s2_r <= pin_s1_r;
		end
	end
	assign pin_low = ~pin_s2_r;

	// Watchdog request from its own timing domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_s1_r <= 1'b0;
			wdt_s2_r <= 1'b0;
			wdt_s3_r <= 1'b0;
		end else begin
			wdt_s1_r <= watchdog_overflow;
			wdt_s2_r <= wdt_s1_r;
			wdt_s3_r <= wdt_s2_r;
		end
	end
	assign wdt_req = wdt_s2_r & ~wdt_s3_r;

	// Reset source decode
	assign stop_op = opcode_fetch && (fetch_opcode == OP_STOP);
	assign seq_illegal_opcode_flag = (state_r == S_RUN) && (illegal_opcode_detect
		|| (stop_op && prev_prefix_r)
		|| (stop_op && !option_r[OPT_STOP_EN_BIT]));
	assign seq_illegal_address_flag = (state_r == S_RUN) && opcode_fetch && fetch_unmapped;
	assign seq_wdt = (state_r == S_RUN) && wdt_req && !option_r[OPT_WDT_DIS_BIT];
	assign seq_lvi = low_voltage_detect && option_r[OPT_LV_PWR_BIT]
		&& option_r[OPT_LV_RST_BIT];
	assign int_src = seq_illegal_opcode_flag || seq_illegal_address_flag || seq_wdt;
	assign enter_stop = (state_r == S_RUN) && stop_op && !prev_prefix_r
		&& option_r[OPT_STOP_EN_BIT] && !int_src && !pin_low
		&& !power_on_pulse && !seq_lvi;
	assign clr_prescale = power_on_pulse || int_src || enter_stop
		|| (seq_lvi && state_r != S_LONG);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_prefix_r <= 1'b0;
		end else if (opcode_fetch) begin
			prev_prefix_r <= (fetch_opcode == OP_SP_PREFIX);
		end
	end

	// Sequence state machine
	always_comb begin
		state_nxt = state_r;
		seq_nxt = tick ? seq_r + SEQ_W'(1) : seq_r;
		case (state_r)
			S_RUN: begin
				seq_nxt = '0;
				if (int_src) begin
					state_nxt = S_DRIVE;
				end else if (pin_low) begin
					state_nxt = S_EXT;
				end else if (enter_stop) begin
					state_nxt = S_STOP;
				end
			end
			S_LONG: begin
				if (tick && count_done(seq_r, LONG_CYCLES)) begin
					state_nxt = S_DRIVE;
					seq_nxt = '0;
				end
			end
			S_DRIVE: begin
				if (tick && count_done(seq_r, PIN_DRIVE_CYCLES)) begin
					state_nxt = S_HOLD;
					seq_nxt = '0;
				end
			end
			S_HOLD: begin
				if (pin_low) begin
					seq_nxt = '0;
				end else if (tick && count_done(seq_r, RESET_HOLD_CYCLES)) begin
					state_nxt = S_RUN;
					seq_nxt = '0;
				end
			end
			S_EXT: begin
				seq_nxt = '0;
				if (!pin_low) begin
					state_nxt = S_HOLD;
				end
			end
			S_STOP: begin
				seq_nxt = '0;
				if (wake_event) begin
					state_nxt = S_RECOVER;
				end
			end
			S_RECOVER: begin
				if (tick && count_done(seq_r, option_r[OPT_SHORT_STOP_BIT]
					? SHORT_STOP_CYCLES : LONG_CYCLES)) begin
					state_nxt = S_RUN;
					seq_nxt = '0;
				end
			end
			default: begin
				state_nxt = S_RUN;
				seq_nxt = '0;
			end
		endcase
		// Power-on and low voltage restart the long count from any state
		if (power_on_pulse || seq_lvi) begin
			state_nxt = S_LONG;
			seq_nxt = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= S_LONG;
			seq_r <= '0;
		end else begin
			state_r <= state_nxt;
			seq_r <= seq_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_lvi_r <= 1'b1;
		end else if (power_on_pulse || seq_lvi) begin
			por_lvi_r <= 1'b1;
		end else if (state_r == S_RUN) begin
			por_lvi_r <= 1'b0;
		end
	end

	// Prescale counter and watchdog clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_r <= '0;
			wdt_clk_r <= 1'b0;
		end else begin
			wdt_clk_r <= tick && !clr_prescale && (&prescale_r);
			if (clr_prescale) begin
				prescale_r <= '0;
			end else if (tick) begin
				prescale_r <= prescale_r + PRESCALE_W'(1);
			end
		end
	end

	// Pin low time qualification
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_cnt_r <= '0;
		end else if (!pin_low) begin
			pin_cnt_r <= '0;
		end else if (tick && !(&pin_cnt_r)) begin
			pin_cnt_r <= pin_cnt_r + SEQ_W'(1);
		end
	end

	logic pin_qual;
	assign pin_qual = pin_low && tick && count_done(pin_cnt_r,
		por_lvi_r ? PIN_THR_LONG : PIN_THR_OTHER);

	// Cause flags; set wins over a software clear
	logic [7:0] cause_set;
	always_comb begin
		cause_set = '0;
		cause_set[CAUSE_PIN_BIT] = pin_qual;
		cause_set[CAUSE_WDT_BIT] = seq_wdt;
		cause_set[CAUSE_ILLEGAL_OPCODE_FLAG_BIT] = seq_illegal_opcode_flag;
		cause_set[CAUSE_ILLEGAL_ADDRESS_FLAG_BIT] = seq_illegal_address_flag;
		cause_set[CAUSE_LVI_BIT] = seq_lvi && !power_on_pulse;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_r <= CAUSE_RESET;
		end else if (power_on_pulse) begin
			cause_r <= CAUSE_RESET;
		end else begin
			cause_r <= ((cause_r & ~((wr_en && paddr == CAUSE_ADDR) ? pwdata[7:0] : 8'h00))
				| cause_set) & CAUSE_MASK;
		end
	end

	// APB slave, one wait state
	assign wr_en = psel && penable && pwrite && pready_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option_r <= OPTION_RESET;
		end else if (internal_reset_r && state_r != S_LONG && state_r != S_STOP) begin
			option_r <= OPTION_RESET;
		end else if (wr_en && paddr == OPTION_ADDR) begin
			option_r <= pwdata[4:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else if (psel && penable && !pready_r) begin
			pready_r <= 1'b1;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
			if (paddr == CAUSE_ADDR) begin
				prdata_r <= {24'h000000, cause_r};
			end else if (paddr == OPTION_ADDR) begin
				prdata_r <= {27'h0000000, option_r};
			end else if (paddr == STATE_ADDR) begin
				prdata_r <= {13'h0000, state_r, 4'h0, prescale_r};
			end else begin
				pslverr_r <= 1'b1;
			end
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// Registered system outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_oe_r <= 1'b1;
			internal_reset_r <= 1'b1;
			mclk_r <= 1'b1;
			bus_clk_r <= 1'b0;
			vector_r <= VEC_USER;
		end else begin
			rst_oe_r <= (state_nxt == S_LONG) || (state_nxt == S_DRIVE);
			internal_reset_r <= (state_nxt != S_RUN) && (state_nxt != S_STOP)
				&& (state_nxt != S_RECOVER);
			mclk_r <= 1'b1;
			bus_clk_r <= (state_nxt != S_LONG) && (state_nxt != S_STOP)
				&& (state_nxt != S_RECOVER);
			vector_r <= monitor_mode ? VEC_MONITOR : VEC_USER;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe = rst_oe_r;
	assign internal_reset = internal_reset_r;
	assign reset_vector = vector_r;
	assign main_clock_out = mclk_r;
	assign internal_bus_clocks = bus_clk_r;
	assign watchdog_clk = wdt_clk_r;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_vector;
		##1 reset_vector == ($past(monitor_mode) ? VEC_MONITOR : VEC_USER);
	endproperty
	a_vector: assert property (p_vector) else $error("reset vector wrong");
	property p_drive;
		state_r == S_DRIVE |-> rst_pin_oe && internal_reset;
	endproperty
	a_drive: assert property (p_drive) else $error("pin not driven");
	property p_hold;
		state_r == S_HOLD && !pin_low && tick && seq_r == SEQ_W'(RESET_HOLD_CYCLES - 1)
			&& !power_on_pulse && !seq_lvi |=> !internal_reset && !rst_pin_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("hold exit wrong");
	property p_wdt;
		seq_wdt && !power_on_pulse && !seq_lvi
			|=> cause_r[CAUSE_WDT_BIT] && state_r == S_DRIVE ##1 prescale_r <= 12'h001;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset missed");
	property p_por;
		power_on_pulse |=> cause_r == CAUSE_RESET && state_r == S_LONG && !internal_bus_clocks;
	endproperty
	a_por: assert property (p_por) else $error("power-on state wrong");
	property p_pin_flag;
		$rose(cause_r[CAUSE_PIN_BIT]) |-> $past(pin_cnt_r) == SEQ_W'(por_lvi_r ?
			PIN_THR_LONG - 1 : PIN_THR_OTHER - 1) || $past(por_lvi_r) != por_lvi_r;
	endproperty
	a_pin_flag: assert property (p_pin_flag) else $error("pin flag early");
	property p_stop_clear;
		enter_stop |=> prescale_r == '0 && state_r == S_STOP;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear");
	property p_ext_keep;
		state_r == S_EXT && !tick && !power_on_pulse && !seq_lvi |=> $stable(prescale_r);
	endproperty
	a_ext_keep: assert property (p_ext_keep) else $error("pin reset moved counter");
	property p_long;
		state_r == S_LONG ##1 state_r == S_LONG |-> rst_pin_oe && !internal_bus_clocks
			&& main_clock_out;
	endproperty
	a_long: assert property (p_long) else $error("long phase outputs wrong");
	property p_lvi;
		seq_lvi && !power_on_pulse |=> cause_r[CAUSE_LVI_BIT] ##1 internal_reset && rst_pin_oe;
	endproperty
	a_lvi: assert property (p_lvi) else $error("low voltage reset missed");

	c_illegal_opcode_flag: cover property (seq_illegal_opcode_flag ##1 state_r == S_DRIVE);
	c_ext: cover property (state_r == S_EXT ##[1:1000] state_r == S_HOLD);
	c_stop: cover property (state_r == S_STOP ##[1:100] state_r == S_RECOVER);
	c_pin_flag: cover property ($rose(cause_r[CAUSE_PIN_BIT]));
endmodule : reset_sequencer

// file: testbench/ext_reset_chip.sv
// Model of an outside chip sharing the reset line: pulls it low on request, times low periods.
// Assumes a pull-up on the line and one tick per oscillator falling edge.
`timescale 1ns/10ps
module ext_reset_chip (
	// Clock
	input wire logic pclk,
	input wire logic tick,
	// Reset line
	input wire logic pin_level,
	input wire logic [15:0] pull_ticks,
	input wire logic pull_go,
	output logic pull_low,
	output logic [15:0] low_seen
);
	logic [15:0] left_r = 16'h0000;
	logic [15:0] run_r = 16'h0000;
	logic [15:0] seen_r = 16'h0000;
	always @(posedge pclk) begin
		if (pull_go)
			left_r <= pull_ticks;
		else if (tick && left_r != 16'h0000)
			left_r <= left_r - 16'h0001;
		if (!pin_level && tick)
			run_r <= run_r + 16'h0001;
		else if (pin_level && run_r != 16'h0000) begin
			seen_r <= run_r;
			run_r <= 16'h0000;
		end
	end
	assign pull_low = (left_r != 16'h0000);
	assign low_seen = seen_r;
endmodule : ext_reset_chip

// file: testbench/reset_sequencer_tb.sv
// Self-checking bench for the reset sequencer, long counts shortened to 64.
// Assumes the package constants and an oscillator at a quarter of pclk.
`timescale 1ns/10ps
module reset_sequencer_tb import reset_seq_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0] div = 2'h0;
	logic osc = 0, por = 0, wdt = 0, lvd = 0, ofetch = 0, unm = 0, bad = 0, wake = 0;
	logic mon = 0, pull_go = 0, slv, pin, pull_low, pready, pslverr, rst_pin_out, rst_pin_oe;
	logic internal_reset, main_clock_out, internal_bus_clocks, watchdog_clk;
	logic [7:0] opc = 8'h00;
	logic [15:0] pull_n = 16'h0000, low_seen, reset_vector;
	int errors = 0, total_checks = 0, ticks = 0, cyc = 0;

	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		div <= div + 2'h1;
		osc <= div[1];
		ticks <= ticks + int'(div == 2'h0);
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			$display("[ERR] %0t timeout", $time);
			errors++;
			final_report;
		end
	end
	// Line with pull-up
	assign pin = !((rst_pin_oe && !rst_pin_out) || pull_low);

	reset_sequencer #(.LONG_CYCLES(64), .PIN_THR_LONG(131)) u_reset_sequencer (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_buffered_clk(osc), .power_on_pulse(por), .watchdog_overflow(wdt),
		.low_voltage_detect(lvd), .opcode_fetch(ofetch), .fetch_opcode(opc),
		.fetch_unmapped(unm), .illegal_opcode_detect(bad), .wake_event(wake),
		.monitor_mode(mon), .rst_pin_in(pin), .rst_pin_out(rst_pin_out),
		.rst_pin_oe(rst_pin_oe), .internal_reset(internal_reset),
		.reset_vector(reset_vector), .main_clock_out(main_clock_out),
		.internal_bus_clocks(internal_bus_clocks), .watchdog_clk(watchdog_clk));
	ext_reset_chip u_ext_reset_chip (.pclk(pclk), .tick(div == 2'h0), .pin_level(pin),
		.pull_ticks(pull_n), .pull_go(pull_go), .pull_low(pull_low), .low_seen(low_seen));

	task final_report;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task chkr(input int g, input int e);
		total_checks++;
		if (g < e - 3 || g > e + 3) begin
			errors++;
			$display("[ERR] %0t ticks %0d expected %0d", $time, g, e);
		end
	endtask : chkr
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		slv = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rdc(input logic [31:0] e);
		apb(0, CAUSE_ADDR, 32'h0);
		chk(rd, e);
		apb(1, CAUSE_ADDR, 32'hFF);
	endtask : rdc
	task seq(input int lo, input int all);
		int t0;
		t0 = ticks;
		repeat (5) @(posedge pclk);
		chk(internal_reset, 1'b1);
		while (internal_reset === 1'b1) @(posedge pclk);
		chkr(ticks - t0, all);
		chkr(int'(low_seen), lo);
	endtask : seq
	task fetch(input logic [7:0] o, input logic u);
		@(posedge pclk);
		ofetch <= 1;
		opc <= o;
		unm <= u;
		@(posedge pclk);
		ofetch <= 0;
		unm <= 0;
	endtask : fetch
	task stop_rec(input logic [31:0] opt, input int n);
		int t0;
		apb(1, OPTION_ADDR, opt);
		fetch(OP_STOP, 0);
		repeat (10) @(posedge pclk);
		chk(internal_bus_clocks, 1'b0);
		wake <= 1;
		@(posedge pclk);
		wake <= 0;
		t0 = ticks;
		while (internal_bus_clocks !== 1'b1) @(posedge pclk);
		chkr(ticks - t0, n);
		chk(internal_reset, 1'b0);
	endtask : stop_rec

	task t_por;
		repeat (6) @(posedge pclk);
		chk(internal_reset, 1'b1);
		chk(internal_bus_clocks, 1'b0);
		chk(main_clock_out, 1'b1);
		chk(reset_vector, VEC_USER);
		presetn <= 1;
		seq(96, 128);
		chk(internal_bus_clocks, 1'b1);
		rdc(CAUSE_RESET);
		apb(0, OPTION_ADDR, 32'h0);
		chk(rd, 32'h0);
		apb(0, 12'h00C, 32'h0);
		chk(slv, 1'b1);
		mon <= 1;
		repeat (3) @(posedge pclk);
		chk(reset_vector, VEC_MONITOR);
		mon <= 0;
		$display("done power-on and bus");
	endtask : t_por
	task t_bad_op;
		bad <= 1;
		@(posedge pclk);
		bad <= 0;
		seq(32, 64);
		rdc(32'h10);
		fetch(OP_STOP, 0);
		seq(32, 64);
		rdc(32'h10);
		apb(1, OPTION_ADDR, 32'h02);
		fetch(OP_SP_PREFIX, 0);
		fetch(OP_STOP, 0);
		seq(32, 64);
		rdc(32'h10);
		$display("done opcode resets");
	endtask : t_bad_op
	task t_wdog;
		apb(1, OPTION_ADDR, 32'h01);
		wdt <= 1;
		repeat (8) @(posedge pclk);
		chk(internal_reset, 1'b0);
		wdt <= 0;
		apb(1, OPTION_ADDR, 32'h00);
		wdt <= 1;
		repeat (3) @(posedge pclk);
		wdt <= 0;
		seq(32, 64);
		rdc(32'h20);
		$display("done watchdog");
	endtask : t_wdog
	task t_bad_addr;
		@(posedge pclk);
		unm <= 1;
		@(posedge pclk);
		unm <= 0;
		repeat (8) @(posedge pclk);
		chk(internal_reset, 1'b0);
		fetch(8'h00, 1);
		seq(32, 64);
		rdc(32'h08);
		stop_rec(32'h06, 32);
		stop_rec(32'h02, 64);
		$display("done address and stop");
	endtask : t_bad_addr
	task t_pin(input logic [15:0] n, input logic [31:0] e);
		pull_n <= n;
		pull_go <= 1;
		@(posedge pclk);
		pull_go <= 0;
		seq(int'(n), int'(n) + 32);
		rdc(e);
	endtask : t_pin
	task t_lowv;
		apb(1, OPTION_ADDR, 32'h08);
		lvd <= 1;
		@(posedge pclk);
		lvd <= 0;
		repeat (8) @(posedge pclk);
		chk(internal_reset, 1'b0);
		apb(1, OPTION_ADDR, 32'h18);
		lvd <= 1;
		@(posedge pclk);
		lvd <= 0;
		seq(96, 128);
		rdc(32'h02);
		$display("done low voltage");
	endtask : t_lowv
	task t_por_pulse;
		por <= 1;
		@(posedge pclk);
		por <= 0;
		seq(96, 128);
		rdc(CAUSE_RESET);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		seq(96, 128);
		rdc(CAUSE_RESET);
		$display("done power-on pulse and mid-run reset");
	endtask : t_por_pulse
	task t_wdclk;
		int t0;
		bad <= 1;
		@(posedge pclk);
		bad <= 0;
		t0 = ticks;
		while (watchdog_clk !== 1'b1) @(posedge pclk);
		chkr(ticks - t0, 4096);
		rdc(32'h10);
		$display("done prescale overflow");
	endtask : t_wdclk

	initial begin
		t_por;
		t_bad_op;
		t_wdog;
		t_bad_addr;
		t_pin(16'h0028, 32'h00);
		t_pin(16'h0050, 32'h40);
		apb(0, STATE_ADDR, 32'h0);
		chk(rd[11:0] > 12'h064, 1'b1);
		$display("done pin resets");
		t_lowv;
		t_por_pulse;
		t_wdclk;
		final_report;
	end
endmodule : reset_sequencer_tb
